// *** design/deser_cfg_pkg.sv ***
// constants, field layout and types of the deserializer configuration bank
// assumes one 25 MHz core clock and a serial control bus sampled on that clock
package deser_cfg_pkg;

   // ----------------------------------------
   // register indices and reset values
   // ----------------------------------------
   localparam int NUM_REGS = 3;
   localparam logic [7:0] IDX_MAIN_CONFIG = 8'h00;
   localparam logic [7:0] IDX_BUS_ADDRESS = 8'h01;
   localparam logic [7:0] IDX_OUTPUT_FEATURES = 8'h02;
   localparam logic [7:0] RST_MAIN_CONFIG = 8'h00;
   localparam logic [7:0] RST_BUS_ADDRESS = 8'h70;
   localparam logic [7:0] RST_OUTPUT_FEATURES = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int MAIN_LOW_FREQ = 7;
   localparam int MAIN_PCLK_SLEW = 6;
   localparam int MAIN_DATA_SLEW = 5;
   localparam int MAIN_STROBE = 4;
   localparam int MAIN_MODE_HI = 3;
   localparam int MAIN_MODE_LO = 2;
   localparam int MAIN_SLEEP = 1;
   localparam int MAIN_REG_SRC = 0;
   localparam int ADDR_SRC = 7;
   localparam int ADDR_HI = 6;
   localparam int FEAT_RELEASE = 7;
   localparam int FEAT_SLEEP_TRI = 6;
   localparam int FEAT_MAP_HI = 5;
   localparam int FEAT_MAP_LO = 4;
   localparam int FEAT_BYPASS = 3;
   localparam int FEAT_OSC_HI = 2;

   // ----------------------------------------
   // strap-selected bus addresses
   // ----------------------------------------
   localparam logic [6:0] STRAP_ADDR_0 = 7'h71;
   localparam logic [6:0] STRAP_ADDR_1 = 7'h72;
   localparam logic [6:0] STRAP_ADDR_2 = 7'h73;
   localparam logic [6:0] STRAP_ADDR_3 = 7'h76;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_FREQ_MHZ = 25;
   localparam int STARTUP_TIME_US = 10000;
   localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_FREQ_MHZ;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      mode_normal_unfiltered,
      mode_normal_filtered,
      mode_legacy_a,
      mode_legacy_b
   } op_mode_t;

   typedef struct packed {
      logic low_freq_range;
      logic pixel_clock_slew_boost;
      logic data_slew_boost;
      logic strobe_edge_select;
      op_mode_t op_mode;
   } pin_cfg_t;

   typedef struct packed {
      pin_cfg_t core;
      logic sleep;
      logic sleep_output_state_select;
      logic [1:0] legacy_lsb_map;
      logic [2:0] internal_osc_freq_select;
      logic outputs_force_low;
   } dev_cfg_t;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_addr_ack,
      st_pointer,
      st_write_ack,
      st_write_data,
      st_read_data,
      st_read_ack
   } bus_state_t;

endpackage : deser_cfg_pkg

// *** design/deser_config_register_bank.sv ***
// configuration register bank of the video link deserializer, behind an
// i2c-compatible serial control bus; effective settings leave as a struct
// assumes scl/sda and all straps are synchronous to clk and far slower than it
//
// Summary of operation
// - register 0 bit 7 picks low (5-20 MHz) or normal pixel clock range
// - register 0 bit 6 boosts pixel clock output slew
// - register 0 bit 5 boosts data output slew
// - register 0 bit 4 picks rising or falling output strobe edge
// - register 0 bits 3:2 pick normal, filtered or one of two legacy modes
// - register 0 bit 1 enters sleep; registers keep their contents
// - register 0 bit 0 takes settings from registers instead of pins
// - register 1 bit 7 takes bus address from register instead of strap
// - register 2 bit 7 low forces outputs low; high releases them
// - the force-low control only takes effect while link is locked
// - register 2 bit 6 picks low or tri-state outputs during sleep
// - register 2 bits 5:4 pick the extra colour lsb in legacy modes set from register 0
// - in register mode, register 2 bit 3 disables force-low feature regardless of strap
// - registers 0 and 2 reset to zero, register 1 to 0x70
// - writing 0x01 to register 0 hands configuration to registers
// - device acks its address and each written byte, stops on stop
`timescale 1ns/1ps

module deser_config_register_bank #(
   parameter int STARTUP_CYCLES = deser_cfg_pkg::STARTUP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial control bus, open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // straps and link status
   input wire logic [1:0] address_strap_pin,
   input wire deser_cfg_pkg::pin_cfg_t pin_cfg,
   input wire logic force_low_strap,
   input wire logic link_locked,
   // effective configuration
   output deser_cfg_pkg::dev_cfg_t cfg,
   output logic [6:0] device_bus_address,
   output logic bus_ready
);

   localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = idx < 8'(deser_cfg_pkg::NUM_REGS);
   endfunction : is_mapped

   function automatic logic [7:0] reset_value(input int idx);
      unique case (idx)
         1: reset_value = deser_cfg_pkg::RST_BUS_ADDRESS;
         2: reset_value = deser_cfg_pkg::RST_OUTPUT_FEATURES;
         default: reset_value = deser_cfg_pkg::RST_MAIN_CONFIG;
      endcase
   endfunction : reset_value

   function automatic logic [6:0] strap_address(input logic [1:0] code);
      unique case (code)
         2'h0: strap_address = deser_cfg_pkg::STRAP_ADDR_0;
         2'h1: strap_address = deser_cfg_pkg::STRAP_ADDR_1;
         2'h2: strap_address = deser_cfg_pkg::STRAP_ADDR_2;
         default: strap_address = deser_cfg_pkg::STRAP_ADDR_3;
      endcase
   endfunction : strap_address

   // ----------------------------------------
   // storage and state
   // ----------------------------------------
   logic [7:0] regs [0:deser_cfg_pkg::NUM_REGS-1];
   deser_cfg_pkg::bus_state_t state;
   deser_cfg_pkg::bus_state_t next_state;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic rw;
   logic next_rw;
   logic ack_phase;
   logic next_ack_phase;
   logic next_drive;
   logic wr_en;
   logic scl_q;
   logic sda_q;
   logic [CNT_W-1:0] startup_cnt;
   deser_cfg_pkg::dev_cfg_t next_cfg;
   logic [6:0] next_address;

   // ----------------------------------------
   // bus event decode
   // ----------------------------------------
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
   wire [7:0] rx_byte = {shift[6:0], sda_in};
   wire last_bit = bit_cnt == deser_cfg_pkg::BYTE_LAST_BIT;
   wire addr_match = rx_byte[7:1] == device_bus_address;
   wire [7:0] rd_byte = is_mapped(ptr) ? regs[ptr[1:0]] : deser_cfg_pkg::UNMAPPED_READ;
   wire tx_bit = rd_byte[deser_cfg_pkg::BYTE_LAST_BIT - bit_cnt];
   wire [7:0] ptr_inc = ptr + 8'h01;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // ----------------------------------------
   // start-up hold-off
   // ----------------------------------------
   // the bus stays deaf until the delay expires, so an early host just sees nacks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         startup_cnt <= '0;
         bus_ready <= 1'b0;
      end else if (!bus_ready) begin
         startup_cnt <= startup_cnt + CNT_W'(1);
         bus_ready <= startup_cnt == CNT_W'(STARTUP_CYCLES - 1);
      end
   end

   // ----------------------------------------
   // serial bus slave
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_ptr = ptr;
      next_rw = rw;
      next_ack_phase = ack_phase;
      next_drive = sda_oe;
      wr_en = 1'b0;
      if (!bus_ready) begin
         next_state = deser_cfg_pkg::st_idle;
         next_drive = 1'b0;
      end else if (start_cond) begin
         next_state = deser_cfg_pkg::st_addr;
         next_bit_cnt = '0;
         next_drive = 1'b0;
      end else if (stop_cond) begin
         next_state = deser_cfg_pkg::st_idle;
         next_drive = 1'b0;
      end else begin
         unique case (state)
            deser_cfg_pkg::st_idle: begin
               next_drive = 1'b0;
            end
            deser_cfg_pkg::st_addr,
            deser_cfg_pkg::st_pointer,
            deser_cfg_pkg::st_write_data: begin
               if (scl_rise) begin
                  next_shift = rx_byte;
                  next_bit_cnt = bit_cnt + 3'h1;
                  next_ack_phase = 1'b0;
                  if (last_bit) begin
                     if (state == deser_cfg_pkg::st_addr) begin
                        next_rw = sda_in;
                        next_state = addr_match ? deser_cfg_pkg::st_addr_ack : deser_cfg_pkg::st_idle;
                     end else if (state == deser_cfg_pkg::st_pointer) begin
                        next_ptr = rx_byte;
                        next_state = deser_cfg_pkg::st_write_ack;
                     end else begin
                        wr_en = 1'b1;
                        next_ptr = ptr_inc;
                        next_state = deser_cfg_pkg::st_write_ack;
                     end
                  end
               end
            end
            deser_cfg_pkg::st_addr_ack,
            deser_cfg_pkg::st_write_ack: begin
               if (scl_fall) begin
                  if (!ack_phase) begin
                     next_drive = 1'b1;
                     next_ack_phase = 1'b1;
                  end else begin
                     next_ack_phase = 1'b0;
                     next_bit_cnt = '0;
                     if (state == deser_cfg_pkg::st_addr_ack && rw) begin
                        next_state = deser_cfg_pkg::st_read_data;
                        next_drive = ~rd_byte[7];
                     end else begin
                        next_drive = 1'b0;
                        next_state = state == deser_cfg_pkg::st_addr_ack ?
                                     deser_cfg_pkg::st_pointer : deser_cfg_pkg::st_write_data;
                     end
                  end
               end
            end
            deser_cfg_pkg::st_read_data: begin
               if (scl_fall) begin
                  next_drive = ~tx_bit;
               end
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (last_bit) begin
                     next_state = deser_cfg_pkg::st_read_ack;
                  end
               end
            end
            deser_cfg_pkg::st_read_ack: begin
               if (scl_fall) begin
                  next_drive = 1'b0;
               end
               if (scl_rise) begin
                  next_bit_cnt = '0;
                  // a master nack ends the read and returns us to idle at once, before any stop
                  if (!sda_in) begin
                     next_ptr = ptr_inc;
                     next_state = deser_cfg_pkg::st_read_data;
                  end else begin
                     next_state = deser_cfg_pkg::st_idle;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= deser_cfg_pkg::st_idle;
         bit_cnt <= '0;
         shift <= '0;
         ptr <= '0;
         rw <= 1'b0;
         ack_phase <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         ptr <= next_ptr;
         rw <= next_rw;
         ack_phase <= next_ack_phase;
         sda_oe <= next_drive;
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   // out-of-range pointers still ack, but nothing is stored
   genvar gi;
   generate
      for (gi = 0; gi < deser_cfg_pkg::NUM_REGS; gi++) begin : g_reg
         wire hit = wr_en & is_mapped(ptr) & (ptr[1:0] == 2'(gi));
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               regs[gi] <= reset_value(gi);
            end else if (hit) begin
               regs[gi] <= rx_byte;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // effective configuration
   // ----------------------------------------
   wire [7:0] main_reg = regs[0];
   wire [7:0] addr_reg = regs[1];
   wire [7:0] feat_reg = regs[2];
   wire reg_src = main_reg[deser_cfg_pkg::MAIN_REG_SRC];
   wire legacy = main_reg[deser_cfg_pkg::MAIN_MODE_HI];
   wire feature_on = force_low_strap & ~(reg_src & feat_reg[deser_cfg_pkg::FEAT_BYPASS]);

   assign next_cfg.core.low_freq_range = reg_src ?
      main_reg[deser_cfg_pkg::MAIN_LOW_FREQ] : pin_cfg.low_freq_range;
   assign next_cfg.core.pixel_clock_slew_boost = reg_src ?
      main_reg[deser_cfg_pkg::MAIN_PCLK_SLEW] : pin_cfg.pixel_clock_slew_boost;
   assign next_cfg.core.data_slew_boost = reg_src ?
      main_reg[deser_cfg_pkg::MAIN_DATA_SLEW] : pin_cfg.data_slew_boost;
   assign next_cfg.core.strobe_edge_select = reg_src ?
      main_reg[deser_cfg_pkg::MAIN_STROBE] : pin_cfg.strobe_edge_select;
   assign next_cfg.core.op_mode = reg_src ?
      deser_cfg_pkg::op_mode_t'(main_reg[deser_cfg_pkg::MAIN_MODE_HI:deser_cfg_pkg::MAIN_MODE_LO]) :
      pin_cfg.op_mode;
   // sleep has no pin of its own, so pin mode never sleeps
   assign next_cfg.sleep = reg_src & main_reg[deser_cfg_pkg::MAIN_SLEEP];
   assign next_cfg.sleep_output_state_select = reg_src & feat_reg[deser_cfg_pkg::FEAT_SLEEP_TRI];
   // the lsb map means nothing outside legacy modes, so it reads as 00 there
   assign next_cfg.legacy_lsb_map = (reg_src & legacy) ?
      feat_reg[deser_cfg_pkg::FEAT_MAP_HI:deser_cfg_pkg::FEAT_MAP_LO] : 2'h0;
   assign next_cfg.internal_osc_freq_select = reg_src ?
      feat_reg[deser_cfg_pkg::FEAT_OSC_HI:0] : 3'h0;
   // while unlocked the force state is frozen, so writes then have no visible effect
   assign next_cfg.outputs_force_low = link_locked ?
      (feature_on & ~feat_reg[deser_cfg_pkg::FEAT_RELEASE]) : cfg.outputs_force_low;
   assign next_address = addr_reg[deser_cfg_pkg::ADDR_SRC] ?
      addr_reg[deser_cfg_pkg::ADDR_HI:0] : strap_address(address_strap_pin);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg <= '0;
         device_bus_address <= deser_cfg_pkg::STRAP_ADDR_0;
      end else begin
         cfg <= next_cfg;
         device_bus_address <= next_address;
      end
   end

endmodule : deser_config_register_bank

// *** verification/deser_config_register_bank_monitor.sv ***
// assertions on the ports of the configuration bank
// assumes one clk domain with synchronous active-low reset; bound below
`timescale 1ns/1ps

module deser_config_register_bank_monitor #(
   parameter int STARTUP_CYCLES = deser_cfg_pkg::STARTUP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial control bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // straps and link status
   input wire logic [1:0] address_strap_pin,
   input wire deser_cfg_pkg::pin_cfg_t pin_cfg,
   input wire logic force_low_strap,
   input wire logic link_locked,
   // effective configuration
   input wire deser_cfg_pkg::dev_cfg_t cfg,
   input wire logic [6:0] device_bus_address,
   input wire logic bus_ready
);
   // edges since reset release, saturating; the start-up delay is far too long for a delay range
   int ready_cnt;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ready_cnt <= 0;
      end else if (ready_cnt < STARTUP_CYCLES) begin
         ready_cnt <= ready_cnt + 1;
      end
   end

   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // --------
   // properties
   // --------
   chk_reset_vals: assert property ($rose(rst_n) |-> cfg == 14'h0 && device_bus_address == 7'h71 && !bus_ready)
      else $error("outputs not at reset values");
   chk_ready_time: assert property (bus_ready == (ready_cnt >= STARTUP_CYCLES))
      else $error("bus ready at wrong time");
   chk_ready_holds: assert property (bus_ready |=> bus_ready)
      else $error("bus ready dropped");
   chk_no_early_ack: assert property (!bus_ready |-> !sda_oe)
      else $error("data line driven before ready");
   chk_drain_only: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("data line driven high");
   chk_ack_on_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data line changed while bus clock high");
   chk_lock_hold: assert property (!link_locked && !$past(link_locked) |=> $stable(cfg.outputs_force_low))
      else $error("force low changed while unlocked");
   chk_strap_off: assert property ((!force_low_strap && link_locked) [*3] |-> !cfg.outputs_force_low)
      else $error("force low active with strap off");
   chk_lsb_map: assert property (cfg.legacy_lsb_map != 2'h0 |-> cfg.core.op_mode[1])
      else $error("lsb map outside legacy mode");

   cover property ($rose(sda_oe));
   cover property ($rose(bus_ready));
   cover property (cfg.legacy_lsb_map == 2'h1);
endmodule : deser_config_register_bank_monitor

bind deser_config_register_bank deser_config_register_bank_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES))
   deser_config_register_bank_monitor_i (
   .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .address_strap_pin(address_strap_pin), .pin_cfg(pin_cfg), .force_low_strap(force_low_strap),
   .link_locked(link_locked), .cfg(cfg), .device_bus_address(device_bus_address), .bus_ready(bus_ready)
);

// *** verification/bus_host.sv ***
// serial control bus host: open-drain master with one register access task
// assumes a pull-up on the data line and a clk far faster than the bus
`timescale 1ns/1ps

module bus_host #(
   parameter int HALF = 4
) (
   // clock
   input wire logic clk,
   // bus
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // --------
   // bus phases
   // --------
   // data moves together with the clock fall, never while the clock is high
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      sda_pull <= ~b;
      repeat (HALF) @(posedge clk);
      scl <= 1'b1;
      repeat (HALF) @(posedge clk);
      r = sda;
   endtask : bit_io

   // start is line_cond(1, 0), stop is line_cond(0, 1)
   task automatic line_cond(input logic a, input logic b);
      scl <= 1'b0;
      sda_pull <= ~a;
      repeat (HALF) @(posedge clk);
      scl <= 1'b1;
      repeat (HALF) @(posedge clk);
      sda_pull <= ~b;
      repeat (HALF) @(posedge clk);
   endtask : line_cond

   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(last, r);
      ack = ~r;
   endtask : xfer

   task automatic access(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] wr,
                         input logic rd_op, output logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, a3;
      line_cond(1'b1, 1'b0);
      xfer({dev, 1'b0}, 1'b1, rx, a0);
      xfer(ptr, 1'b1, rx, a1);
      if (rd_op) begin
         line_cond(1'b1, 1'b0);
         xfer({dev, 1'b1}, 1'b1, rx, a2);
         xfer(8'hFF, 1'b1, data, a3);
      end else begin
         xfer(wr, 1'b1, rx, a2);
      end
      line_cond(1'b0, 1'b1);
      ok = a0 & a1 & a2;
   endtask : access
endmodule : bus_host

// *** verification/deser_config_register_bank_tb.sv ***
// testbench of the configuration bank: row table of writes, then edge cases
// assumes a pull-up on the data line; start-up delay shortened to 200 cycles
`timescale 1ns/1ps

module deser_config_register_bank_tb;
   localparam logic [6:0] DEV = 7'h76;
   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] wr;
      logic [7:0] rd;
      logic [13:0] cfg;
   } row_t;
   row_t rows [8] = '{
      '{8'h00, 8'h01, 8'h01, 14'h0001},
      '{8'h00, 8'hFF, 8'hFF, 14'h3F81},
      '{8'h02, 8'h7F, 8'h7F, 14'h3FFE},
      '{8'h02, 8'h85, 8'h85, 14'h3F8A},
      '{8'h02, 8'h18, 8'h18, 14'h3F90},
      '{8'h00, 8'h09, 8'h09, 14'h0210},
      '{8'h03, 8'h55, 8'h00, 14'h0210},
      '{8'h00, 8'h00, 8'h00, 14'h1501}
   };
   logic [6:0] straps [4] = '{7'h71, 7'h72, 7'h73, 7'h76};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic force_low_strap = 1'b1;
   logic link_locked = 1'b1;
   logic [1:0] address_strap_pin = 2'h3;
   deser_cfg_pkg::pin_cfg_t pin_cfg = 6'h15;
   deser_cfg_pkg::dev_cfg_t cfg;
   logic scl, sda_pull, sda_out, sda_oe, bus_ready, ok;
   logic [6:0] device_bus_address;
   logic [7:0] rd;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   wire sda = !(sda_pull || (sda_oe && !sda_out));

   deser_config_register_bank #(.STARTUP_CYCLES(200)) deser_config_register_bank_i (
      .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .address_strap_pin(address_strap_pin), .pin_cfg(pin_cfg), .force_low_strap(force_low_strap),
      .link_locked(link_locked), .cfg(cfg), .device_bus_address(device_bus_address), .bus_ready(bus_ready)
   );
   bus_host bus_host_i (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));

   always #20 clk = ~clk;

   // --------
   // checking and run control
   // --------
   task automatic complete_run();
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_val

   task automatic check_cfg(input deser_cfg_pkg::dev_cfg_t got, input logic [13:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t cfg got %h expected %h", $time, got, exp);
      end
   endtask : check_cfg

   // early access must go unanswered; reset values read back once ready
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check_cfg(cfg, 14'h0);
      check_val({1'b0, device_bus_address}, 8'h71, "reset address");
      @(posedge clk);
      bus_host_i.access(DEV, 8'h00, 8'h01, 1'b0, rd, ok);
      check_val({7'h00, ok}, 8'h00, "early ack");
      for (int i = 0; i < 300 && bus_ready !== 1'b1; i++) @(posedge clk);
      for (int p = 0; p < 3; p++) begin
         bus_host_i.access(DEV, 8'(p), 8'h00, 1'b1, rd, ok);
         check_val(rd, (p == 1) ? 8'h70 : 8'h00, "reset value");
      end
   endtask : do_reset

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         complete_run();
      end
   end

   initial begin
      do_reset();
      for (int s = 0; s < 4; s++) begin
         address_strap_pin <= 2'(s);
         repeat (4) @(posedge clk);
         check_val({1'b0, device_bus_address}, {1'b0, straps[s]}, "strap address");
      end
      bus_host_i.access(7'h70, 8'h00, 8'hFF, 1'b0, rd, ok);
      check_val({7'h00, ok}, 8'h00, "foreign address acked");
      foreach (rows[k]) begin
         bus_host_i.access(DEV, rows[k].ptr, rows[k].wr, 1'b0, rd, ok);
         check_val({7'h00, ok}, 8'h01, "write ack");
         bus_host_i.access(DEV, rows[k].ptr, 8'h00, 1'b1, rd, ok);
         check_val(rd, rows[k].rd, "read back");
         check_cfg(cfg, rows[k].cfg);
      end
      bus_host_i.access(DEV, 8'h01, 8'hF5, 1'b0, rd, ok);
      repeat (4) @(posedge clk);
      check_val({1'b0, device_bus_address}, 8'h75, "register address");
      bus_host_i.access(7'h75, 8'h01, 8'h00, 1'b1, rd, ok);
      check_val(rd, 8'hF5, "read at new address");
      bus_host_i.access(7'h75, 8'h01, 8'h00, 1'b0, rd, ok);
      link_locked <= 1'b0;
      bus_host_i.access(DEV, 8'h02, 8'h80, 1'b0, rd, ok);
      check_val({7'h00, cfg.outputs_force_low}, 8'h01, "force low while unlocked");
      link_locked <= 1'b1;
      repeat (4) @(posedge clk);
      check_val({7'h00, cfg.outputs_force_low}, 8'h00, "force low released");
      bus_host_i.access(DEV, 8'h02, 8'h00, 1'b0, rd, ok);
      check_val({7'h00, cfg.outputs_force_low}, 8'h01, "force low set");
      force_low_strap <= 1'b0;
      repeat (4) @(posedge clk);
      check_val({7'h00, cfg.outputs_force_low}, 8'h00, "strap off");
      // two data bytes in one frame from register 1, then a current-address read that acks once
      bus_host_i.line_cond(1'b1, 1'b0);
      bus_host_i.xfer({DEV, 1'b0}, 1'b1, rd, ok);
      bus_host_i.xfer(8'h01, 1'b1, rd, ok);
      bus_host_i.xfer(8'h3C, 1'b1, rd, ok);
      bus_host_i.xfer(8'h46, 1'b1, rd, ok);
      check_val({7'h00, ok}, 8'h01, "second byte ack");
      bus_host_i.line_cond(1'b0, 1'b1);
      bus_host_i.access(DEV, 8'h01, 8'h00, 1'b1, rd, ok);
      check_val(rd, 8'h3C, "burst first byte");
      bus_host_i.line_cond(1'b1, 1'b0);
      bus_host_i.xfer({DEV, 1'b1}, 1'b1, rd, ok);
      bus_host_i.xfer(8'hFF, 1'b0, rd, ok);
      check_val(rd, 8'h3C, "current address read");
      bus_host_i.xfer(8'hFF, 1'b1, rd, ok);
      check_val(rd, 8'h46, "burst second byte");
      bus_host_i.line_cond(1'b0, 1'b1);
      do_reset();
      complete_run();
   end
endmodule : deser_config_register_bank_tb
